// ---- design/drive_words_regs.svh ----
/*
 * Bit positions and reset values of the drive command word and the drive state word.
 * Assumes inclusion by bare name from the design module and the bench.
 */
`ifndef DRIVE_WORDS_REGS_SVH
`define DRIVE_WORDS_REGS_SVH
// Overview of operation
// - Command bits 0..1 pick one of four preset references.
// - Command bit 2 low requests DC braking and stop.
// - Command bit 3 low switches the output stage off; motor coasts.
// - Command bit 4 low requests a quick-stop ramp down.
// - Command bit 5 low freezes output frequency; only coast or brake stop it.
// - Command bit 6 low ramps to stop; high permits start.
// - Trip clears only on a rising edge of command bit 7.
// - Command bit 8 high selects jog speed.
// - Command bit 9 selects ramp set one or two.
// - Command word ignored entirely unless bit 10 is high.
// - Bits 11 and 12 drive relays only when relay function selects them.
// - Bits 13..14 select set-up only under multi set-up configuration.
// - Bit 15 reverses only for serial, OR or AND reversing source.
// - State bits 0..2 report control ready, drive ready, output enabled.
// - State bits 3, 4, 6 report trip, non-trip error, trip lock.
// - State bit 7 reports warning; bit 5 stays zero.
// - State bit 8 high when speed equals reference.
// - State bit 9 high under bus control, low under local stop or reference.
// - State bit 10 high while frequency lies inside the speed limits.
// - State bit 11 high with start signal or nonzero output frequency.
// - State bit 12 high while halted by temporary overtemperature.
// - State bits 13..15 report voltage, current limit, thermal timer excess.
// - Whole state word is zero when the option link is lost.
`define CMD_REF_LSB      0
`define CMD_DC_BRAKE_N   2
`define CMD_COAST_N      3
`define CMD_QSTOP_N      4
`define CMD_FREEZE_N     5
`define CMD_RUN          6
`define CMD_RESET        7
`define CMD_JOG          8
`define CMD_RAMP2        9
`define CMD_VALID        10
`define CMD_RELAY1       11
`define CMD_RELAY2       12
`define CMD_SETUP_LSB    13
`define CMD_REVERSE      15
`define STATE_CTRL_READY  0
`define STATE_DRIVE_READY 1
`define STATE_OUT_ENABLED 2
`define STATE_TRIP        3
`define STATE_ERROR       4
`define STATE_UNUSED      5
`define STATE_TRIP_LOCK   6
`define STATE_WARNING     7
`define STATE_AT_SPEED    8
`define STATE_BUS_CTRL    9
`define STATE_IN_LIMITS   10
`define STATE_RUNNING     11
`define STATE_OT_HALT     12
`define STATE_VOLTAGE     13
`define STATE_CURRENT     14
`define STATE_THERMAL     15
`define CMD_RESET_VALUE  16'h0000
`define STATE_RESET_VALUE 16'h0000
`endif

// ---- design/drive_words_pkg.sv ----
/*
 * Types shared by the command decoder.
 * Assumes the bit layout header is on the include path.
 */
package drive_words_pkg;
    typedef enum logic [1:0] {
        REV_DIGITAL,
        REV_SERIAL,
        REV_LOGIC_OR,
        REV_LOGIC_AND
    } reverse_source_type;

    typedef struct packed {
        logic       control_ready;
        logic       drive_ready;
        logic       output_enabled;
        logic       tripped;
        logic       error_no_trip;
        logic       trip_locked;
        logic       warning;
        logic       speed_at_ref;
        logic       local_stop;
        logic       local_reference;
        logic       freq_in_limits;
        logic       start_present;
        logic       freq_nonzero;
        logic       overtemp_halt;
        logic       voltage_fault;
        logic       current_limit;
        logic       thermal_exceeded;
        logic       link_lost;
    } drive_condition_type;

    typedef struct packed {
        logic [1:0] preset_select;
        logic       dc_brake;
        logic       coast;
        logic       quick_stop;
        logic       freeze;
        logic       ramp_stop;
        logic       jog;
        logic       ramp_set2;
        logic [1:0] setup_select;
        logic       reverse;
    } drive_command_type;
endpackage

// ---- design/drive_words.sv ----
/*
 * Decoder of the fieldbus command word and builder of the drive state word.
 * Assumes command words arrive with a one-cycle strobe on sys_clk, and that the
 * drive condition inputs and configuration come from logic on the same clock.
 */
`include "drive_words_regs.svh"

module drive_words
    import drive_words_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Received command word
    input  wire logic [15:0]         drive_command_word,
    input  wire logic                command_strobe,
    // Configuration
    input  wire logic                relay1_fn_is_bit,
    input  wire logic                relay2_fn_is_bit,
    input  wire logic                multi_setup_active,
    input  wire reverse_source_type  reverse_source,
    input  wire logic                reverse_input,
    // Drive conditions
    input  wire drive_condition_type cond,
    // Decoded commands
    output logic                     commands_valid_reg,
    output drive_command_type        command_reg,
    output logic                     trip_clear_reg,
    output logic                     relay1_reg,
    output logic                     relay2_reg,
    output logic                     setup_change_reg,
    output logic [1:0]               setup_reg,
    // State word
    output logic [15:0]              drive_state_word
);

    // ************************************************************
    // Command latch
    // ************************************************************
    logic [15:0] word_reg;
    logic        reset_bit_reg;
    logic [15:0] word_next;
    logic        reverse_allowed;

    assign word_next = drive_command_word;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_reg           <= `CMD_RESET_VALUE;
            commands_valid_reg <= 1'b0;
        end else if (command_strobe && drive_command_word[`CMD_VALID]) begin
            word_reg           <= word_next;
            commands_valid_reg <= 1'b1;
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    always_comb begin
        case (reverse_source)
            REV_SERIAL:    reverse_allowed = 1'b1;
            REV_LOGIC_OR:  reverse_allowed = 1'b1;
            REV_LOGIC_AND: reverse_allowed = 1'b1;
            default:       reverse_allowed = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            command_reg <= '0;
        end else begin
            command_reg.preset_select <= word_reg[`CMD_REF_LSB +: 2];
            command_reg.dc_brake      <= ~word_reg[`CMD_DC_BRAKE_N];
            command_reg.coast         <= ~word_reg[`CMD_COAST_N];
            command_reg.quick_stop    <= ~word_reg[`CMD_QSTOP_N];
            command_reg.freeze        <= ~word_reg[`CMD_FREEZE_N];
            command_reg.ramp_stop     <= ~word_reg[`CMD_RUN];
            command_reg.jog           <= word_reg[`CMD_JOG];
            command_reg.ramp_set2     <= word_reg[`CMD_RAMP2];
            command_reg.setup_select  <= word_reg[`CMD_SETUP_LSB +: 2];
            case (reverse_source)
                REV_SERIAL:    command_reg.reverse <= word_reg[`CMD_REVERSE];
                REV_LOGIC_OR:  command_reg.reverse <= word_reg[`CMD_REVERSE] | reverse_input;
                REV_LOGIC_AND: command_reg.reverse <= word_reg[`CMD_REVERSE] & reverse_input;
                default:       command_reg.reverse <= reverse_input;
            endcase
        end
    end

    // ************************************************************
    // Trip clear on rising reset bit
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_bit_reg  <= 1'b0;
            trip_clear_reg <= 1'b0;
        end else begin
            reset_bit_reg  <= word_reg[`CMD_RESET];
            trip_clear_reg <= word_reg[`CMD_RESET] & ~reset_bit_reg;
        end
    end

    // ************************************************************
    // Relays and set-up
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relay1_reg       <= 1'b0;
            relay2_reg       <= 1'b0;
            setup_reg        <= 2'h0;
            setup_change_reg <= 1'b0;
        end else begin
            relay1_reg       <= relay1_fn_is_bit & word_reg[`CMD_RELAY1];
            relay2_reg       <= relay2_fn_is_bit & word_reg[`CMD_RELAY2];
            setup_change_reg <= 1'b0;
            if (multi_setup_active &&
                setup_reg != word_reg[`CMD_SETUP_LSB +: 2]) begin
                setup_reg        <= word_reg[`CMD_SETUP_LSB +: 2];
                setup_change_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // State word
    // ************************************************************
    logic [15:0] state_next;

    always_comb begin
        state_next     = `STATE_RESET_VALUE;
        state_next[`STATE_CTRL_READY]  = cond.control_ready;
        state_next[`STATE_DRIVE_READY] = cond.drive_ready;
        state_next[`STATE_OUT_ENABLED] = cond.output_enabled;
        state_next[`STATE_TRIP]        = cond.tripped;
        state_next[`STATE_ERROR]       = cond.error_no_trip;
        state_next[`STATE_UNUSED]      = 1'b0;
        state_next[`STATE_TRIP_LOCK]   = cond.trip_locked;
        state_next[`STATE_WARNING]     = cond.warning;
        state_next[`STATE_AT_SPEED]    = cond.speed_at_ref;
        state_next[`STATE_BUS_CTRL]    = ~(cond.local_stop | cond.local_reference);
        state_next[`STATE_IN_LIMITS]   = cond.freq_in_limits;
        state_next[`STATE_RUNNING]     = cond.start_present | cond.freq_nonzero;
        state_next[`STATE_OT_HALT]     = cond.overtemp_halt;
        state_next[`STATE_VOLTAGE]     = cond.voltage_fault;
        state_next[`STATE_CURRENT]     = cond.current_limit;
        state_next[`STATE_THERMAL]     = cond.thermal_exceeded;
        if (cond.link_lost) begin
            state_next = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_state_word <= `STATE_RESET_VALUE;
        end else begin
            drive_state_word <= state_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_valid_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && !drive_command_word[`CMD_VALID]) |=> $stable(word_reg);
    endproperty
    a_valid_gate: assert property (p_valid_gate) else $error("invalid word latched");

    property p_latch;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> word_reg == $past(drive_command_word);
    endproperty
    a_latch: assert property (p_latch) else $error("command word not latched");

    property p_coast;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID] && !drive_command_word[`CMD_COAST_N])
            |=> ##1 command_reg.coast;
    endproperty
    a_coast: assert property (p_coast) else $error("coast not decoded");

    property p_brake;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.dc_brake == !$past(drive_command_word[`CMD_DC_BRAKE_N], 2);
    endproperty
    a_brake: assert property (p_brake) else $error("brake decode wrong");

    property p_trip_edge;
        @(posedge sys_clk) disable iff (sys_rst)
        trip_clear_reg |-> $past(word_reg[`CMD_RESET]) && !$past(reset_bit_reg);
    endproperty
    a_trip_edge: assert property (p_trip_edge) else $error("trip clear without edge");

    property p_trip_once;
        @(posedge sys_clk) disable iff (sys_rst)
        trip_clear_reg |=> !trip_clear_reg;
    endproperty
    a_trip_once: assert property (p_trip_once) else $error("trip clear repeated");

    property p_relay;
        @(posedge sys_clk) disable iff (sys_rst)
        relay1_reg |-> $past(relay1_fn_is_bit) && $past(word_reg[`CMD_RELAY1]);
    endproperty
    a_relay: assert property (p_relay) else $error("relay active without selection");

    property p_setup;
        @(posedge sys_clk) disable iff (sys_rst)
        !multi_setup_active |=> $stable(setup_reg);
    endproperty
    a_setup: assert property (p_setup) else $error("setup changed outside multi");

    property p_link_lost;
        @(posedge sys_clk) disable iff (sys_rst)
        cond.link_lost |=> drive_state_word == 16'h0000;
    endproperty
    a_link_lost: assert property (p_link_lost) else $error("state word not zero");

    property p_bit5;
        @(posedge sys_clk) disable iff (sys_rst)
        !drive_state_word[`STATE_UNUSED];
    endproperty
    a_bit5: assert property (p_bit5) else $error("unused state bit set");

    property p_preset;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.preset_select ==
                $past(drive_command_word[`CMD_REF_LSB +: 2], 2);
    endproperty
    a_preset: assert property (p_preset) else $error("preset select not decoded");

    property p_quick_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.quick_stop == !$past(drive_command_word[`CMD_QSTOP_N], 2);
    endproperty
    a_quick_stop: assert property (p_quick_stop) else $error("quick stop not decoded");

    property p_freeze;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.freeze == !$past(drive_command_word[`CMD_FREEZE_N], 2);
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze not decoded");

    property p_ramp_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.ramp_stop == !$past(drive_command_word[`CMD_RUN], 2);
    endproperty
    a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop not decoded");

    property p_jog;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.jog == $past(drive_command_word[`CMD_JOG], 2);
    endproperty
    a_jog: assert property (p_jog) else $error("jog not decoded");

    property p_ramp_set;
        @(posedge sys_clk) disable iff (sys_rst)
        (command_strobe && drive_command_word[`CMD_VALID])
            |=> ##1 command_reg.ramp_set2 == $past(drive_command_word[`CMD_RAMP2], 2);
    endproperty
    a_ramp_set: assert property (p_ramp_set) else $error("ramp set not decoded");

    property p_reverse_local;
        @(posedge sys_clk) disable iff (sys_rst)
        !reverse_allowed |=> command_reg.reverse == $past(reverse_input);
    endproperty
    a_reverse_local: assert property (p_reverse_local) else $error("reverse bit obeyed");

    property p_reverse_bus;
        @(posedge sys_clk) disable iff (sys_rst)
        (reverse_source == REV_SERIAL) |=> command_reg.reverse == $past(word_reg[`CMD_REVERSE]);
    endproperty
    a_reverse_bus: assert property (p_reverse_bus) else $error("reverse bit ignored");

    property p_relay2;
        @(posedge sys_clk) disable iff (sys_rst)
        relay2_reg |-> $past(relay2_fn_is_bit) && $past(word_reg[`CMD_RELAY2]);
    endproperty
    a_relay2: assert property (p_relay2) else $error("relay two without selection");

    property p_setup_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        setup_change_reg |-> setup_reg != $past(setup_reg);
    endproperty
    a_setup_pulse: assert property (p_setup_pulse) else $error("setup pulse without change");

    property p_state_trip;
        @(posedge sys_clk) disable iff (sys_rst)
        !cond.link_lost |=> drive_state_word[`STATE_TRIP] == $past(cond.tripped);
    endproperty
    a_state_trip: assert property (p_state_trip) else $error("trip bit wrong");

    property p_bus_ctrl;
        @(posedge sys_clk) disable iff (sys_rst)
        (!cond.link_lost && cond.local_stop) |=> !drive_state_word[`STATE_BUS_CTRL];
    endproperty
    a_bus_ctrl: assert property (p_bus_ctrl) else $error("bus control under local stop");

    property p_running;
        @(posedge sys_clk) disable iff (sys_rst)
        (!cond.link_lost && cond.freq_nonzero) |=> drive_state_word[`STATE_RUNNING];
    endproperty
    a_running: assert property (p_running) else $error("running bit low");

    c_trip: cover property (@(posedge sys_clk) disable iff (sys_rst) trip_clear_reg);
    c_setup: cover property (@(posedge sys_clk) disable iff (sys_rst) setup_change_reg);
    c_lost: cover property (@(posedge sys_clk) disable iff (sys_rst) cond.link_lost);
    c_ignored: cover property (@(posedge sys_clk) disable iff (sys_rst)
        command_strobe && !drive_command_word[`CMD_VALID]);

endmodule

// ---- testbench/fieldbus_master_model.sv ----
/*
 * Behavioural fieldbus master that hands received command words to the decoder.
 * Assumes the decoder samples the word on the rising edge of sys_clk while the strobe is high.
 */
module fieldbus_master_model (
    // Clock
    input  wire logic        sys_clk,
    // Command word towards the drive
    output logic [15:0]      drive_command_word,
    output logic             command_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        drive_command_word = 16'h0000;
        command_strobe     = 1'b0;
    end

    // ************************************************************
    // Word transfer
    // ************************************************************
    // Outside the strobe the lines show the inverse of the last word, so stale data never matches
    task automatic send(input logic [15:0] w);
        @(negedge sys_clk);
        drive_command_word = w;
        command_strobe     = 1'b1;
        @(negedge sys_clk);
        command_strobe     = 1'b0;
        drive_command_word = ~w;
    endtask
endmodule

// ---- testbench/drive_control_status_words_tb_top.sv ----
/*
 * Self-checking bench for the command decoder and state word builder.
 * Assumes the design sources and the bit layout header are on the include path.
 */
`include "drive_words_regs.svh"

module drive_control_status_words_tb_top
    import drive_words_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic                sys_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [15:0]         drive_command_word;
    logic                command_strobe;
    logic                relay1_fn_is_bit = 1'b0;
    logic                relay2_fn_is_bit = 1'b0;
    logic                multi_setup_active = 1'b0;
    reverse_source_type  reverse_source = REV_DIGITAL;
    logic                reverse_input = 1'b0;
    drive_condition_type cond = '0;
    logic                commands_valid_reg;
    drive_command_type   command_reg;
    logic                trip_clear_reg;
    logic                relay1_reg;
    logic                relay2_reg;
    logic                setup_change_reg;
    logic [1:0]          setup_reg;
    logic [15:0]         drive_state_word;
    int                  n_mismatch = 0;
    int                  comparisons = 0;
    drive_command_type   exp_cmd = '0;
    logic                exp_r1 = 1'b0;
    logic                exp_r2 = 1'b0;
    logic [1:0]          exp_setup = 2'h0;
    logic                last_b7 = 1'b0;
    logic [1:0]          held_setup = 2'h0;
    logic [15:0]         words [4] = '{16'h0400, 16'h257D, 16'hC62A, 16'hFFFF};

    always #5 sys_clk = ~sys_clk;

    fieldbus_master_model fieldbus_master_model_inst (
        .sys_clk(sys_clk), .drive_command_word(drive_command_word),
        .command_strobe(command_strobe));

    drive_words drive_words_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .drive_command_word(drive_command_word),
        .command_strobe(command_strobe), .relay1_fn_is_bit(relay1_fn_is_bit),
        .relay2_fn_is_bit(relay2_fn_is_bit), .multi_setup_active(multi_setup_active),
        .reverse_source(reverse_source), .reverse_input(reverse_input), .cond(cond),
        .commands_valid_reg(commands_valid_reg), .command_reg(command_reg),
        .trip_clear_reg(trip_clear_reg), .relay1_reg(relay1_reg), .relay2_reg(relay2_reg),
        .setup_change_reg(setup_change_reg), .setup_reg(setup_reg),
        .drive_state_word(drive_state_word));

    // ************************************************************
    // Compare and closing tasks
    // ************************************************************
    task automatic check_bit(input string name, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_cmd(input drive_command_type e, input drive_command_type g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] command_reg expected %h seen %h", e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Expected values
    // ************************************************************
    function automatic drive_command_type decode(input logic [15:0] w,
                                                 input reverse_source_type s, input logic r);
        logic rev;
        case (s)
            REV_SERIAL:    rev = w[15];
            REV_LOGIC_OR:  rev = w[15] | r;
            REV_LOGIC_AND: rev = w[15] & r;
            default:       rev = r;
        endcase
        return {w[1:0], ~w[2], ~w[3], ~w[4], ~w[5], ~w[6], w[8], w[9], w[14:13], rev};
    endfunction

    function automatic logic [15:0] state_of(input drive_condition_type c);
        if (c.link_lost) return 16'h0000;
        return {c.thermal_exceeded, c.current_limit, c.voltage_fault, c.overtemp_halt,
                c.start_present | c.freq_nonzero, c.freq_in_limits,
                ~(c.local_stop | c.local_reference), c.speed_at_ref, c.warning,
                c.trip_locked, 1'b0, c.error_no_trip, c.tripped, c.output_enabled,
                c.drive_ready, c.control_ready};
    endfunction

    // ************************************************************
    // Sequences
    // ************************************************************
    task automatic command(input logic [15:0] w, input reverse_source_type src, input logic rin,
                           input logic f1, input logic f2, input logic ms);
        logic exp_clear;
        logic exp_chg;
        reverse_source = src;
        reverse_input = rin;
        relay1_fn_is_bit = f1;
        relay2_fn_is_bit = f2;
        multi_setup_active = ms;
        // Multi set-up takes the held selection before the new word lands
        if (ms) exp_setup = held_setup;
        fieldbus_master_model_inst.send(w);
        exp_clear = w[10] & w[7] & ~last_b7;
        exp_chg = w[10] & ms & (w[14:13] != exp_setup);
        if (w[10]) begin
            exp_cmd = decode(w, src, rin);
            exp_r1 = w[11] & f1;
            exp_r2 = w[12] & f2;
            last_b7 = w[7];
            held_setup = w[14:13];
        end
        if (exp_chg) exp_setup = w[14:13];
        @(negedge sys_clk);
        check_cmd(exp_cmd, command_reg);
        check_bit("trip_clear_reg", exp_clear, trip_clear_reg);
        check_bit("relay1_reg", exp_r1, relay1_reg);
        check_bit("relay2_reg", exp_r2, relay2_reg);
        check_word("setup_reg", 16'(exp_setup), 16'(setup_reg));
        check_bit("setup_change_reg", exp_chg, setup_change_reg);
        check_bit("commands_valid_reg", 1'b1, commands_valid_reg);
        @(negedge sys_clk);
        check_bit("trip_clear_reg", 1'b0, trip_clear_reg);
    endtask

    task automatic state(input logic [17:0] v);
        cond = drive_condition_type'(v);
        @(negedge sys_clk);
        check_word("drive_state_word", state_of(cond), drive_state_word);
    endtask

    initial begin
        repeat (5) @(negedge sys_clk);
        check_word("drive_state_word", `STATE_RESET_VALUE, drive_state_word);
        check_bit("commands_valid_reg", 1'b0, commands_valid_reg);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            command(words[i], reverse_source_type'(i), 1'b1, i[0], i[1], 1'b1);
        end
        command(16'hFFFF, REV_LOGIC_AND, 1'b0, 1'b0, 1'b1, 1'b0);
        command(16'h0400, REV_LOGIC_OR, 1'b0, 1'b1, 1'b1, 1'b0);
        command(16'h8880, REV_LOGIC_OR, 1'b0, 1'b1, 1'b1, 1'b0);
        command(16'h0480, REV_LOGIC_OR, 1'b0, 1'b1, 1'b1, 1'b1);
        state(18'h00000);
        for (int k = 0; k < 20; k++) begin
            state(k < 18 ? 18'h1 << k : (k == 18 ? 18'h3FFFE : 18'h3FFFF));
        end
        sys_rst = 1'b1;
        @(negedge sys_clk);
        check_word("drive_state_word", `STATE_RESET_VALUE, drive_state_word);
        check_bit("commands_valid_reg", 1'b0, commands_valid_reg);
        tally_and_finish();
    end

    initial begin
        #50us;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
